// *** lie_pkg.sv ***
// constants shared by the line unit interrupt edge and mask logic
package lie_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 9;
  localparam int TMR_W = 31;
  // channel address blocks: common channel 0 sits apart from channels 1..8
  localparam logic [10:0] CH0_BASE = 11'h7c0;
  localparam logic [10:0] CH_STRIDE = 11'h040;
  localparam logic [10:0] CH_SPAN_MASK = 11'h7c0;
  // register offsets inside a channel block
  localparam logic [10:0] OFF_EDGE_SEL = 11'h01a;
  localparam logic [10:0] OFF_MASK = 11'h01b;
  localparam logic [10:0] OFF_STATUS_A = 11'h01e;
  localparam logic [10:0] OFF_STATUS_B = 11'h01f;
  localparam logic [10:0] OFF_EVENT_A = 11'h030;
  localparam logic [10:0] OFF_EVENT_B = 11'h031;
  // reset values and writable bits
  localparam logic [7:0] EDGE_SEL_RST = 8'h00;
  localparam logic [7:0] EDGE_SEL_WMASK = 8'h7f;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [7:0] EVENT_A_WMASK = 8'hff;
  localparam logic [7:0] EVENT_B_WMASK = 8'he3;
  // edge-select fields
  localparam int ES_ALARM = 6;
  localparam int ES_PATTERN = 5;
  localparam int ES_OVERCUR = 4;
  localparam int ES_CLKLOSS = 3;
  localparam int ES_TXLOSS = 2;
  localparam int ES_RXLOSS = 1;
  localparam int ES_INBAND = 0;
  // mask fields, also the bit layout of event_register_a
  localparam int MB_AMPL = 7;
  localparam int MB_TXFIFO = 6;
  localparam int MB_RXFIFO = 5;
  localparam int MB_OVERCUR = 4;
  localparam int MB_CLKLOSS = 3;
  localparam int MB_TXLOSS = 2;
  localparam int MB_SYSLOSS = 1;
  localparam int MB_LINELOSS = 0;
  // layout of status_register_b and event_register_b
  localparam int SB_SYS_ALARM = 7;
  localparam int SB_LINE_ALARM = 6;
  localparam int SB_PATTERN = 5;
  localparam int SB_ACT = 1;
  localparam int SB_DEACT = 0;
  // activate code persistence times
  localparam longint CLK_MHZ = 250;
  localparam longint ACT_SHORT_MS = 40;
  localparam longint ACT_LONG_DS = 51;
  localparam longint ACT_SHORT_CYC = ACT_SHORT_MS * CLK_MHZ * 64'd1000;
  localparam longint ACT_LONG_CYC = ACT_LONG_DS * CLK_MHZ * 64'd100000;
endpackage

// *** lie_edge_mask.sv ***
// per-channel interrupt edge select, mask and event latching for the line unit
//
// Overview of operation
// (R1) nine channels, common 0 plus 1..8, each own edge-select and mask registers
// (R2) edge bit 6: line and system alarm events on rise, or both edges
// (R3) edge bit 5: pattern sync event on rise, or both edges
// (R4) edge bit 4: driver overcurrent event on rise, or both edges
// (R5) edge bit 3: transmit clock loss event on rise, or both edges
// (R6) edge bit 2: transmit signal loss event on rise, or both edges
// (R7) edge bit 1: line and system signal loss events on rise, or both
// (R8) edge bit 0: activate and deactivate code events on rise, or both
// (R9) edge-select bit 7 reserved; other bits read/write, reset zero
// (R10) mask register read/write, resets to all ones; 0 enables, 1 masks
// (R11) mask bit 7 gates the amplitude overflow interrupt
// (R12) mask bit 6 gates the transmit jitter fifo interrupt
// (R13) mask bit 5 gates the receive jitter fifo interrupt
// (R14) mask bit 4 gates the driver overcurrent interrupt
// (R15) mask bit 3 gates the transmit clock loss interrupt
// (R16) mask bit 2 gates the transmit signal loss interrupt
// (R17) mask bit 1 gates the system signal loss interrupt
// (R18) mask bit 0 gates the line signal loss interrupt
// (R19) activate state set after code held 40 ms, or 5.1 s in auto loopback
// (R20) masked events stay latched and raise the request once unmasked
// (R21) edges found against last cycle's status; event set in same cycle
`timescale 1ns/1ns
module lie_edge_mask
  import lie_pkg::*;
#(
  parameter int N_CH = NUM_CH,
  parameter longint ACT_SHORT_CYCLES = ACT_SHORT_CYC,
  parameter longint ACT_LONG_CYCLES = ACT_LONG_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [N_CH-1:0] line_alarm_signal_state,
  input wire logic [N_CH-1:0] system_alarm_signal_state,
  input wire logic [N_CH-1:0] pattern_sync_state,
  input wire logic [N_CH-1:0] driver_overcurrent_state,
  input wire logic [N_CH-1:0] tx_clock_loss_state,
  input wire logic [N_CH-1:0] tx_signal_loss_state,
  input wire logic [N_CH-1:0] line_signal_loss_state,
  input wire logic [N_CH-1:0] system_signal_loss_state,
  input wire logic [N_CH-1:0] activate_code_detect,
  input wire logic [N_CH-1:0] deactivate_code_state,
  input wire logic [N_CH-1:0] automatic_loopback_enable,
  input wire logic [N_CH-1:0] amplitude_overflow_pulse,
  input wire logic [N_CH-1:0] tx_jitter_fifo_pulse,
  input wire logic [N_CH-1:0] rx_jitter_fifo_pulse,
  output logic [N_CH-1:0] activate_code_state,
  output logic [N_CH-1:0] irq_channel,
  output logic irq
);

  // byte address of one register of one channel
  function automatic logic [ADDR_W-1:0] reg_addr_of(input int ch, input logic [ADDR_W-1:0] off);
    logic [ADDR_W-1:0] base;
    base = (ch == 0) ? CH0_BASE : ADDR_W'(CH_STRIDE * (ch - 1));
    reg_addr_of = base | off;
  endfunction

  // event qualifier: rising only, or any change when the select bit is set
  function automatic logic edge_hit(input logic cur, input logic prv, input logic any_edge);
    edge_hit = any_edge ? (cur ^ prv) : (cur & ~prv);
  endfunction

  localparam logic [TMR_W-1:0] SHORT_LIM = TMR_W'(ACT_SHORT_CYCLES);
  localparam logic [TMR_W-1:0] LONG_LIM = TMR_W'(ACT_LONG_CYCLES);

  // register file per channel
  logic [N_CH-1:0][7:0] edge_sel_ff;
  logic [N_CH-1:0][7:0] nxt_edge_sel;
  logic [N_CH-1:0][7:0] mask_ff;
  logic [N_CH-1:0][7:0] nxt_mask;
  logic [N_CH-1:0][7:0] event_a_ff;
  logic [N_CH-1:0][7:0] nxt_event_a;
  logic [N_CH-1:0][7:0] event_b_ff;
  logic [N_CH-1:0][7:0] nxt_event_b;

  // status vectors and their previous-cycle copies
  logic [N_CH-1:0][7:0] stat_a;
  logic [N_CH-1:0][7:0] stat_b;
  logic [N_CH-1:0][7:0] prev_a_ff;
  logic [N_CH-1:0][7:0] prev_b_ff;
  logic [N_CH-1:0][7:0] set_a;
  logic [N_CH-1:0][7:0] set_b;

  // activate code persistence timers
  logic [N_CH-1:0][TMR_W-1:0] act_cnt_ff;
  logic [N_CH-1:0][TMR_W-1:0] nxt_act_cnt;
  logic [N_CH-1:0] act_state_ff;
  logic [N_CH-1:0] nxt_act_state;

  // read port and request outputs
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic [N_CH-1:0] irq_ch_ff;
  logic [N_CH-1:0] nxt_irq_ch;
  logic irq_ff;
  logic nxt_irq;

  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_ch
      logic hit_es;
      logic hit_mk;
      logic hit_ea;
      logic hit_eb;
      logic [TMR_W-1:0] lim;

      assign hit_es = reg_wr && (reg_addr == reg_addr_of(g, OFF_EDGE_SEL)); // see (R1)
      assign hit_mk = reg_wr && (reg_addr == reg_addr_of(g, OFF_MASK)); // see (R1)
      assign hit_ea = reg_wr && (reg_addr == reg_addr_of(g, OFF_EVENT_A));
      assign hit_eb = reg_wr && (reg_addr == reg_addr_of(g, OFF_EVENT_B));

      // status layouts match the event registers bit for bit
      always_comb begin
        stat_a[g] = 8'h00;
        stat_a[g][MB_OVERCUR] = driver_overcurrent_state[g];
        stat_a[g][MB_CLKLOSS] = tx_clock_loss_state[g];
        stat_a[g][MB_TXLOSS] = tx_signal_loss_state[g];
        stat_a[g][MB_SYSLOSS] = system_signal_loss_state[g];
        stat_a[g][MB_LINELOSS] = line_signal_loss_state[g];
        stat_b[g] = 8'h00;
        stat_b[g][SB_SYS_ALARM] = system_alarm_signal_state[g];
        stat_b[g][SB_LINE_ALARM] = line_alarm_signal_state[g];
        stat_b[g][SB_PATTERN] = pattern_sync_state[g];
        stat_b[g][SB_ACT] = act_state_ff[g];
        stat_b[g][SB_DEACT] = deactivate_code_state[g];
      end

      // edge qualification against last cycle's status
      always_comb begin
        set_a[g] = 8'h00;
        set_a[g][MB_AMPL] = amplitude_overflow_pulse[g];
        set_a[g][MB_TXFIFO] = tx_jitter_fifo_pulse[g];
        set_a[g][MB_RXFIFO] = rx_jitter_fifo_pulse[g];
        set_a[g][MB_OVERCUR] = edge_hit(stat_a[g][MB_OVERCUR], prev_a_ff[g][MB_OVERCUR],
                                        edge_sel_ff[g][ES_OVERCUR]); // see (R4) see (R21)
        set_a[g][MB_CLKLOSS] = edge_hit(stat_a[g][MB_CLKLOSS], prev_a_ff[g][MB_CLKLOSS],
                                        edge_sel_ff[g][ES_CLKLOSS]); // see (R5)
        set_a[g][MB_TXLOSS] = edge_hit(stat_a[g][MB_TXLOSS], prev_a_ff[g][MB_TXLOSS],
                                       edge_sel_ff[g][ES_TXLOSS]); // see (R6)
        set_a[g][MB_SYSLOSS] = edge_hit(stat_a[g][MB_SYSLOSS], prev_a_ff[g][MB_SYSLOSS],
                                        edge_sel_ff[g][ES_RXLOSS]); // see (R7)
        set_a[g][MB_LINELOSS] = edge_hit(stat_a[g][MB_LINELOSS], prev_a_ff[g][MB_LINELOSS],
                                         edge_sel_ff[g][ES_RXLOSS]); // see (R7)
        set_b[g] = 8'h00;
        set_b[g][SB_SYS_ALARM] = edge_hit(stat_b[g][SB_SYS_ALARM], prev_b_ff[g][SB_SYS_ALARM],
                                          edge_sel_ff[g][ES_ALARM]); // see (R2)
        set_b[g][SB_LINE_ALARM] = edge_hit(stat_b[g][SB_LINE_ALARM], prev_b_ff[g][SB_LINE_ALARM],
                                           edge_sel_ff[g][ES_ALARM]); // see (R2)
        set_b[g][SB_PATTERN] = edge_hit(stat_b[g][SB_PATTERN], prev_b_ff[g][SB_PATTERN],
                                        edge_sel_ff[g][ES_PATTERN]); // see (R3)
        set_b[g][SB_ACT] = edge_hit(stat_b[g][SB_ACT], prev_b_ff[g][SB_ACT],
                                    edge_sel_ff[g][ES_INBAND]); // see (R8)
        set_b[g][SB_DEACT] = edge_hit(stat_b[g][SB_DEACT], prev_b_ff[g][SB_DEACT],
                                      edge_sel_ff[g][ES_INBAND]); // see (R8)
      end

      // registers: set beats a write-one clear landing in the same cycle
      always_comb begin
        nxt_edge_sel[g] = edge_sel_ff[g];
        nxt_mask[g] = mask_ff[g];
        if (hit_es) begin
          nxt_edge_sel[g] = reg_wdata & EDGE_SEL_WMASK; // see (R9)
        end
        if (hit_mk) begin
          nxt_mask[g] = reg_wdata; // see (R10)
        end
        nxt_event_a[g] = event_a_ff[g] & ~(hit_ea ? (reg_wdata & EVENT_A_WMASK) : 8'h00);
        nxt_event_a[g] = nxt_event_a[g] | set_a[g]; // see (R21)
        nxt_event_b[g] = event_b_ff[g] & ~(hit_eb ? (reg_wdata & EVENT_B_WMASK) : 8'h00);
        nxt_event_b[g] = nxt_event_b[g] | set_b[g];
      end

      // activate code must persist; the limit follows the auto loopback enable
      assign lim = automatic_loopback_enable[g] ? LONG_LIM : SHORT_LIM; // see (R19)
      always_comb begin
        nxt_act_cnt[g] = act_cnt_ff[g];
        nxt_act_state[g] = 1'b0;
        if (!activate_code_detect[g]) begin
          nxt_act_cnt[g] = '0;
        end else if (act_cnt_ff[g] < lim) begin
          nxt_act_cnt[g] = act_cnt_ff[g] + TMR_W'(1);
        end else begin
          nxt_act_state[g] = 1'b1; // see (R19)
        end
      end

      // masked events are kept; only enabled ones reach the request
      assign nxt_irq_ch[g] = |(event_a_ff[g] & ~mask_ff[g]); // see (R11) see (R12) see (R13) see (R14) see (R20)

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          edge_sel_ff[g] <= EDGE_SEL_RST; // see (R9)
          mask_ff[g] <= MASK_RST; // see (R10)
          event_a_ff[g] <= 8'h00;
          event_b_ff[g] <= 8'h00;
          prev_a_ff[g] <= 8'h00;
          prev_b_ff[g] <= 8'h00;
          act_cnt_ff[g] <= '0;
          act_state_ff[g] <= 1'b0;
          irq_ch_ff[g] <= 1'b0;
        end else if (clk_en) begin
          edge_sel_ff[g] <= nxt_edge_sel[g];
          mask_ff[g] <= nxt_mask[g];
          event_a_ff[g] <= nxt_event_a[g];
          event_b_ff[g] <= nxt_event_b[g];
          prev_a_ff[g] <= stat_a[g]; // see (R21)
          prev_b_ff[g] <= stat_b[g];
          act_cnt_ff[g] <= nxt_act_cnt[g];
          act_state_ff[g] <= nxt_act_state[g];
          irq_ch_ff[g] <= nxt_irq_ch[g]; // see (R15) see (R16) see (R17) see (R18)
        end
      end
    end
  endgenerate

  // read mux; unmapped addresses return zero
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      nxt_rdata = 8'h00;
      for (int c = 0; c < N_CH; c++) begin
        if (reg_addr == reg_addr_of(c, OFF_EDGE_SEL)) begin
          nxt_rdata = edge_sel_ff[c]; // see (R1)
        end
        if (reg_addr == reg_addr_of(c, OFF_MASK)) begin
          nxt_rdata = mask_ff[c];
        end
        if (reg_addr == reg_addr_of(c, OFF_STATUS_A)) begin
          nxt_rdata = stat_a[c];
        end
        if (reg_addr == reg_addr_of(c, OFF_STATUS_B)) begin
          nxt_rdata = stat_b[c];
        end
        if (reg_addr == reg_addr_of(c, OFF_EVENT_A)) begin
          nxt_rdata = event_a_ff[c];
        end
        if (reg_addr == reg_addr_of(c, OFF_EVENT_B)) begin
          nxt_rdata = event_b_ff[c];
        end
      end
    end
  end

  assign nxt_irq = |nxt_irq_ch;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
    end else if (clk_en) begin
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq; // see (R20)
    end
  end

  assign reg_rdata = rdata_ff;
  assign activate_code_state = act_state_ff;
  assign irq_channel = irq_ch_ff;
  assign irq = irq_ff;

endmodule

// *** lie_edge_mask_sva.sv ***
// checker for the line unit interrupt edge and mask block
`timescale 1ns/1ns
module lie_edge_mask_chk
  import lie_pkg::*;
#(
  parameter int N_CH = NUM_CH,
  parameter longint ACT_SHORT_CYCLES = ACT_SHORT_CYC,
  parameter longint ACT_LONG_CYCLES = ACT_LONG_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [N_CH-1:0] activate_code_detect,
  input wire logic [N_CH-1:0] automatic_loopback_enable,
  input wire logic [N_CH-1:0] activate_code_state,
  input wire logic [N_CH-1:0] irq_channel,
  input wire logic irq
);
  // shadow of channel 1 mask and run length of its activate detect
  logic [7:0] mask_sh_ff, nxt_mask_sh;
  longint run_ff, nxt_run;
  always_comb begin
    nxt_mask_sh = mask_sh_ff;
    nxt_run = run_ff;
    if (clk_en) begin
      if (reg_wr && reg_addr == OFF_MASK) begin
        nxt_mask_sh = reg_wdata;
      end
      nxt_run = activate_code_detect[1] ? run_ff + 1 : 0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mask_sh_ff <= MASK_RST;
      run_ff <= 0;
    end else begin
      mask_sh_ff <= nxt_mask_sh;
      run_ff <= nxt_run;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_read(logic [10:0] a);
    clk_en && reg_rd && reg_addr == a;
  endsequence
  a_unmapped_reads_zero: assert property (s_read(11'h03f) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_stands: assert property (clk_en && !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_reserved_bit_zero: assert property (s_read(OFF_EDGE_SEL) |=> reg_rdata[7] == 1'b0)
    else $error("reserved edge select bit reads one");
  a_masked_no_irq: assert property (clk_en && mask_sh_ff == 8'hff |=> !irq_channel[1])
    else $error("fully masked channel raised a request");
  a_irq_is_or: assert property (irq == |irq_channel)
    else $error("summary request differs from channel requests");
  a_act_not_early: assert property ($rose(activate_code_state[1]) |-> run_ff >= ACT_SHORT_CYCLES - 1)
    else $error("activate state set too early");
  a_act_short_late: assert property (activate_code_detect[1] && !automatic_loopback_enable[1]
    && run_ff > ACT_SHORT_CYCLES + 3 |-> activate_code_state[1])
    else $error("activate state missing after short limit");
  a_act_long_wait: assert property (automatic_loopback_enable[1] && run_ff < ACT_LONG_CYCLES - 1
    |-> !activate_code_state[1])
    else $error("activate state set before long limit");
  a_act_drops: assert property ($fell(activate_code_detect[1]) |-> ##[0:2] !activate_code_state[1])
    else $error("activate state held after code left");
endmodule
bind lie_edge_mask lie_edge_mask_chk #(.N_CH(N_CH), .ACT_SHORT_CYCLES(ACT_SHORT_CYCLES),
  .ACT_LONG_CYCLES(ACT_LONG_CYCLES)) u_chk (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .activate_code_detect(activate_code_detect), .automatic_loopback_enable(automatic_loopback_enable),
  .activate_code_state(activate_code_state), .irq_channel(irq_channel), .irq(irq));

// *** lie_edge_mask_tb.sv ***
// self-checking bench for the line unit interrupt edge and mask block
`timescale 1ns/1ns
module lie_edge_mask_tb;
  import lie_pkg::*;
  `define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR %0t: got %h exp %h", $time, got, exp); end end
  // source id: edge select bit and event bit; ids 5..7 are pulses with no edge select
  localparam int ES_OF[12] = '{1, 1, 2, 3, 4, 0, 0, 0, 6, 6, 5, 0};
  localparam int EV_OF[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 6, 7, 5, 0};
  int miscompares = 0, cmp_count = 0;
  logic ref_clk = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, irq;
  logic [10:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata;
  logic [NUM_CH-1:0] la = '0, sa = '0, ps = '0, oc = '0, cl = '0, tl = '0, ll = '0, sl = '0;
  logic [NUM_CH-1:0] act = '0, dea = '0, alb = '0, amp = '0, txf = '0, rxf = '0, act_st, irq_ch;
  lie_edge_mask #(.ACT_SHORT_CYCLES(20), .ACT_LONG_CYCLES(50)) dut (.ref_clk(ref_clk), .reset(reset),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .line_alarm_signal_state(la), .system_alarm_signal_state(sa),
    .pattern_sync_state(ps), .driver_overcurrent_state(oc), .tx_clock_loss_state(cl),
    .tx_signal_loss_state(tl), .line_signal_loss_state(ll), .system_signal_loss_state(sl),
    .activate_code_detect(act), .deactivate_code_state(dea), .automatic_loopback_enable(alb),
    .amplitude_overflow_pulse(amp), .tx_jitter_fifo_pulse(txf), .rx_jitter_fifo_pulse(rxf),
    .activate_code_state(act_st), .irq_channel(irq_ch), .irq(irq));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  function automatic logic [10:0] ra(int ch, logic [10:0] off);
    return (ch == 0 ? CH0_BASE : CH_STRIDE * 11'(ch - 1)) + off;
  endfunction
  task automatic wr(logic [10:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [10:0] a, logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask
  task automatic wait_cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic set_src(int id, logic v);
    @(posedge ref_clk);
    case (id)
      0: ll[1] <= v;
      1: sl[1] <= v;
      2: tl[1] <= v;
      3: cl[1] <= v;
      4: oc[1] <= v;
      5: rxf[1] <= v;
      6: txf[1] <= v;
      7: amp[1] <= v;
      8: la[1] <= v;
      9: sa[1] <= v;
      10: ps[1] <= v;
      default: dea[1] <= v;
    endcase
  endtask
  task automatic clr();
    wr(ra(1, OFF_EVENT_A), 8'hff);
    wr(ra(1, OFF_EVENT_B), 8'hff);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    int n;
    int lim;
    logic [10:0] ea;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    rd(ra(0, OFF_EDGE_SEL), 8'h00);
    rd(ra(8, OFF_MASK), 8'hff);
    wr(ra(1, OFF_EDGE_SEL), 8'hff);
    rd(ra(1, OFF_EDGE_SEL), 8'h7f);
    wr(ra(1, OFF_MASK), 8'h5a);
    rd(ra(1, OFF_MASK), 8'h5a);
    rd(ra(0, OFF_MASK), 8'hff);
    rd(ra(2, OFF_EDGE_SEL), 8'h00);
    rd(11'h03f, 8'h00);
    wr(ra(1, OFF_EDGE_SEL), 8'h00);
    wr(ra(1, OFF_MASK), 8'hff);
    // a low clock enable must freeze the registers against writes
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(ra(1, OFF_MASK), 8'h00);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd(ra(1, OFF_MASK), 8'hff);
    $display("test registers done");
    // rise only by default, then both edges once the select bit is set
    foreach (ES_OF[id]) begin
      if (id < 5 || id > 7) begin
        ea = ra(1, id < 8 ? OFF_EVENT_A : OFF_EVENT_B);
        set_src(id, 1'b1);
        wait_cyc(2);
        rd(ea, 8'h01 << EV_OF[id]);
        rd(ra(1, id < 8 ? OFF_STATUS_A : OFF_STATUS_B), 8'h01 << EV_OF[id]);
        clr();
        set_src(id, 1'b0);
        wait_cyc(2);
        rd(ea, 8'h00);
        wr(ra(1, OFF_EDGE_SEL), 8'h01 << ES_OF[id]);
        set_src(id, 1'b1);
        wait_cyc(2);
        clr();
        set_src(id, 1'b0);
        wait_cyc(2);
        rd(ea, 8'h01 << EV_OF[id]);
        clr();
        wr(ra(1, OFF_EDGE_SEL), 8'h00);
      end
    end
    $display("test edges done");
    // a masked event stays latched; a wrong mask bit must not release it
    for (int b = 0; b < 8; b++) begin
      set_src(b, 1'b1);
      set_src(b, 1'b0);
      wait_cyc(2);
      `CHK(irq, 1'b0)
      rd(ra(1, OFF_EVENT_A), 8'h01 << b);
      wr(ra(1, OFF_MASK), ~(8'h01 << ((b + 1) % 8)));
      wait_cyc(2);
      `CHK(irq, 1'b0)
      wr(ra(1, OFF_MASK), ~(8'h01 << b));
      wait_cyc(2);
      `CHK(irq_ch, 9'h002)
      `CHK(irq, 1'b1)
      wr(ra(1, OFF_EVENT_A), 8'h01 << b);
      wait_cyc(2);
      `CHK(irq, 1'b0)
      wr(ra(1, OFF_MASK), 8'hff);
    end
    $display("test masks done");
    // activate persistence, short limit then long limit
    for (int lp = 0; lp < 2; lp++) begin
      lim = lp == 1 ? 50 : 20;
      @(posedge ref_clk);
      alb[1] <= lp[0];
      act[1] <= 1'b1;
      n = 0;
      while (act_st[1] !== 1'b1 && n < 200) begin
        wait_cyc(1);
        n++;
      end
      if (n == 200) begin
        miscompares++;
        end_of_test();
      end
      `CHK(n >= lim && n <= lim + 2, 1'b1)
      rd(ra(1, OFF_EVENT_B), 8'h02);
      clr();
      @(posedge ref_clk);
      act[1] <= 1'b0;
      wait_cyc(3);
      `CHK(act_st[1], 1'b0)
      rd(ra(1, OFF_EVENT_B), 8'h00);
    end
    $display("test activate done");
    end_of_test();
  end
endmodule
